// ==== bench/test_clock_divider_ratio_select_a_control.sv ====
`timescale 1ns/1ps
module test_clock_divider_ratio_select_a_control;
    import cddc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic [2:0] i_current_osc_select = 3'h7;
    logic i_irq_event = 1'b0;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    cddc_ctrl_t o_ctrl;
    cddc_ticks_t o_ticks;
    logic [31:0] o_rc_hz;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int num_checks = 0;
    int per;
    // 10 MHz system clock
    always #50 i_clk = ~i_clk;
    cddc_top #(.RC_PRESCALE(1)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_current_osc_select(i_current_osc_select), .i_irq_event(i_irq_event),
        .o_ctrl(o_ctrl), .o_ticks(o_ticks), .o_rc_hz(o_rc_hz));
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 50);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, o_pready});
    endtask : apb
    // cycles between two later ticks of rc (sel 0) or peripheral (sel 1)
    task automatic period(input int sel, output int n);
        int k;
        for (int t = 0; t < 2; t++) begin
            k = 0;
            do begin
                @(negedge i_clk);
                k++;
            end while ((sel ? o_ticks.periph_tick : o_ticks.rc_tick) !== 1'b1 && k < 2000);
        end
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while ((sel ? o_ticks.periph_tick : o_ticks.rc_tick) !== 1'b1 && n < 2000);
    endtask : period
    task automatic t_reset_and_mask();
        apb(1'b0, CDDC_ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0000_0100, rd);
        chk("rc hz reset", 32'd4000000, o_rc_hz);
        apb(1'b1, CDDC_ADDR_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, CDDC_ADDR_CTRL, 32'h0);
        chk("ctrl all ones", 32'h0000_FF00, rd);
        apb(1'b1, CDDC_ADDR_CTRL, 32'h0000_00FF);
        apb(1'b0, CDDC_ADDR_CTRL, 32'h0);
        chk("ctrl low byte", 32'h0, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask : t_reset_and_mask
    task automatic t_postscaler();
        logic [2:0] oscs [3] = '{3'h7, 3'h1, 3'h6};
        int div;
        for (int o = 0; o < 3; o++) begin
            for (int c = 0; c < 8; c++) begin
                div = (c == 7) ? 256 : (1 << c);
                @(posedge i_clk);
                i_current_osc_select <= oscs[o];
                apb(1'b1, CDDC_ADDR_CTRL, 32'(c) << 8);
                repeat (3) @(negedge i_clk);
                chk("rc hz", (oscs[o] == 3'h6 ? 500000 : 8000000) / div, o_rc_hz);
                if (o == 0) begin
                    period(0, per);
                    chk("rc period", div, per);
                end
            end
        end
        @(posedge i_clk);
        i_current_osc_select <= 3'h0;
        repeat (3) @(negedge i_clk);
        chk("rc hz other osc", 32'h0, o_rc_hz);
        @(posedge i_clk);
        i_current_osc_select <= 3'h7;
    endtask : t_postscaler
    task automatic t_ratio_select_a();
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, CDDC_ADDR_CTRL, 32'h0800 | (32'(r) << 12));
            period(1, per);
            chk("periph period", 1 << r, per);
        end
        apb(1'b1, CDDC_ADDR_CTRL, 32'h7000);
        period(1, per);
        chk("periph no ratio_select_a", 32'h1, per);
    endtask : t_ratio_select_a
    task automatic t_irq(input logic [31:0] val, input logic keep, input int exp_per);
        apb(1'b1, CDDC_ADDR_CTRL, val);
        @(posedge i_clk);
        i_irq_event <= 1'b1;
        @(posedge i_clk);
        i_irq_event <= 1'b0;
        @(negedge i_clk);
        chk("ratio_select_a after irq", {31'h0, keep}, {31'h0, o_ctrl.ratio_select_a_enable});
        period(1, per);
        chk("periph after irq", exp_per, per);
    endtask : t_irq
    // watchdog against a hang
    initial begin
        #(40000 * 100);
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset_and_mask();
        t_postscaler();
        t_ratio_select_a();
        t_irq(32'h0000_B800, 1'b0, 1);
        t_irq(32'h0000_3800, 1'b1, 8);
        stop_test();
    end
endmodule : test_clock_divider_ratio_select_a_control

// ==== rtl/cddc_pkg.sv ====
package cddc_pkg;
    // register map, byte addresses on the apb bus
    localparam logic [11:0] CDDC_ADDR_CTRL = 12'h000;
    localparam logic [11:0] CDDC_ADDR_STAT = 12'h004;
    // field positions of clock_divider_control
    localparam int CDDC_ROI_BIT = 15;
    localparam int CDDC_RATIO_LSB = 12;
    localparam int CDDC_RATIO_SELECT_A_ENABLE_BIT = 11;
    localparam int CDDC_RC_POSTSCALER_SELECT_LSB = 8;
    // value after reset: postscaler code 001, everything else zero
    localparam logic [15:0] CDDC_CTRL_RESET = 16'h0100;
    localparam logic [15:0] CDDC_CTRL_WMASK = 16'hFF00;
    // current oscillator select codes that feed the postscaler
    localparam logic [2:0] CDDC_CURRENT_OSC_SELECT_FRC = 3'h7;
    localparam logic [2:0] CDDC_CURRENT_OSC_SELECT_FRC_B = 3'h1;
    localparam logic [2:0] CDDC_CURRENT_OSC_SELECT_LPRC = 3'h6;
    // nominal source rates in hz
    localparam int CDDC_FRC_HZ = 8000000;
    localparam int CDDC_LPRC_HZ = 500000;

    // decoded control fields
    typedef struct packed {
        logic recover_on_interrupt;
        logic [2:0] ratio_select_a;
        logic ratio_select_a_enable;
        logic [2:0] rc_postscaler_select;
    } cddc_ctrl_t;

    // clock enable outputs
    typedef struct packed {
        logic rc_tick;
        logic cpu_tick;
        logic periph_tick;
    } cddc_ticks_t;
endpackage : cddc_pkg

// ==== rtl/cddc_pow2_div.sv ====
`timescale 1ns/1ps
// divides an enable stream by 2^code, pulse on the last of each group
module cddc_pow2_div #(
    parameter int MAXLOG = 8
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst, // async reset, active high
    input wire logic i_en, // input tick
    input wire logic [3:0] i_log2, // divide by 2^i_log2
    output logic o_tick // output tick
);
    logic [MAXLOG-1:0] cnt_reg;
    logic [MAXLOG-1:0] mask;

    initial begin
        if (MAXLOG < 1 || MAXLOG > 15) $error("cddc_pow2_div: MAXLOG out of range");
    end

    // mask of counter bits used by the current code
    always_comb begin
        mask = MAXLOG'((17'h00001 << i_log2) - 17'h00001);
    end

    // counter cleared at the end of each group; a code change takes effect via masking without restarting the count
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= '0;
        end else if (i_en) begin
            if ((cnt_reg & mask) == mask) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + MAXLOG'(1);
            end
        end
    end

    assign o_tick = i_en && ((cnt_reg & mask) == mask);
endmodule : cddc_pow2_div

// ==== rtl/cddc_top.sv ====
`timescale 1ns/1ps
// Function
// - roi set: interrupt clears ratio_select_a, ratio 1:1
// - roi clear: interrupts leave ratio_select_a enable alone
// - ratio field bits 14:12 gives 1:2^code
// - ratio_select_a enabled: apply ratio field to peripheral
// - ratio_select_a disabled: cpu and peripheral same rate
// - postscaler bits 10:8 divide rc by 2^code, code 111 by 256
// - osc 111/001: 8 MHz down to 31.25 kHz
// - postscaler resets to 001, divide by two
// - osc 110: 500 kHz down to 1.95 kHz
// - unimplemented bits ignore writes, read zero
module cddc_top #(
    parameter int RC_PRESCALE = 1 // system cycles per rc tick, models the rc source
) (
    input wire logic i_clk, // system clock, 10 MHz
    input wire logic i_rst, // async reset, active high
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic i_pwrite, // apb direction
    input wire logic [11:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error
    input wire logic [2:0] i_current_osc_select, // code from oscillator controller
    input wire logic i_irq_event, // interrupt occurred, one-cycle pulse
    output cddc_pkg::cddc_ctrl_t o_ctrl, // registered control fields
    output cddc_pkg::cddc_ticks_t o_ticks, // clock enables
    output logic [31:0] o_rc_hz // nominal postscaler output rate
);
    import cddc_pkg::*;

    cddc_ctrl_t ctrl_reg;
    logic [2:0] current_osc_select_reg;
    logic [31:0] rc_hz_reg;
    logic [31:0] prdata_reg;
    logic [15:0] ctrl_word;
    logic wr_ctrl;
    logic rd_en;
    logic addr_ok;
    logic [15:0] wdata;
    logic [7:0] pre_cnt_reg;
    logic src_tick;
    logic rc_tick;
    logic periph_tick;
    logic [3:0] rc_log2;
    logic [3:0] ratio_select_a_log2;
    logic osc_valid;

    initial begin
        if (RC_PRESCALE < 1 || RC_PRESCALE > 255) $error("cddc_top: RC_PRESCALE out of range");
    end

    // apb decode; zero wait states
    assign addr_ok = (i_paddr == CDDC_ADDR_CTRL) || (i_paddr == CDDC_ADDR_STAT);
    assign wr_ctrl = i_psel && i_penable && i_pwrite && (i_paddr == CDDC_ADDR_CTRL);
    assign rd_en = i_psel && !i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;
    assign wdata = i_pwdata[15:0] & CDDC_CTRL_WMASK;

    assign ctrl_word = {ctrl_reg, 8'h00};

    // control register; an interrupt beats a write of ratio_select_a enable when the written roi bit is set
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= cddc_ctrl_t'(CDDC_CTRL_RESET[15:8]);
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= cddc_ctrl_t'(wdata[15:8]);
            end
            if (i_irq_event && (wr_ctrl ? wdata[CDDC_ROI_BIT] : ctrl_reg.recover_on_interrupt)) begin
                ctrl_reg.ratio_select_a_enable <= 1'b0;
            end
            // roi clear: ratio_select_a_enable untouched by interrupts
        end
    end

    // oscillator code from a separate controller on the same clock
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            current_osc_select_reg <= CDDC_CURRENT_OSC_SELECT_FRC;
        end else begin
            current_osc_select_reg <= i_current_osc_select;
        end
    end

    // read data latched during setup
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prdata_reg <= 32'h00000000;
        end else if (rd_en) begin
            case (i_paddr)
                CDDC_ADDR_CTRL: prdata_reg <= {16'h0000, ctrl_word};
                CDDC_ADDR_STAT: prdata_reg <= {25'h0000000, osc_valid, current_osc_select_reg,
                    ctrl_reg.rc_postscaler_select};
                default: prdata_reg <= 32'h00000000;
            endcase
        end
    end
    assign o_prdata = prdata_reg;

    // postscaler source presence and divide code
    assign osc_valid = (current_osc_select_reg == CDDC_CURRENT_OSC_SELECT_FRC) || (current_osc_select_reg == CDDC_CURRENT_OSC_SELECT_FRC_B)
        || (current_osc_select_reg == CDDC_CURRENT_OSC_SELECT_LPRC);
    // code 111 skips divide-by-128 and goes straight to divide-by-256
    assign rc_log2 = (ctrl_reg.rc_postscaler_select == 3'h7) ? 4'h8
        : {1'b0, ctrl_reg.rc_postscaler_select};

    // nominal rate: source rate shifted by the code
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rc_hz_reg <= 32'h00000000;
        end else begin
            case (current_osc_select_reg)
                CDDC_CURRENT_OSC_SELECT_FRC, CDDC_CURRENT_OSC_SELECT_FRC_B: rc_hz_reg <= 32'(CDDC_FRC_HZ) >> rc_log2;
                CDDC_CURRENT_OSC_SELECT_LPRC: rc_hz_reg <= 32'(CDDC_LPRC_HZ) >> rc_log2;
                default: rc_hz_reg <= 32'h00000000;
            endcase
        end
    end
    assign o_rc_hz = rc_hz_reg;

    // rc source tick model
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_cnt_reg <= 8'h00;
        end else if (pre_cnt_reg == 8'(RC_PRESCALE - 1)) begin
            pre_cnt_reg <= 8'h00;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
        end
    end
    assign src_tick = osc_valid && (pre_cnt_reg == 8'(RC_PRESCALE - 1));

    // rc postscaler
    cddc_pow2_div #(.MAXLOG(8)) u_rc_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_en(src_tick),
        .i_log2(rc_log2),
        .o_tick(rc_tick)
    );

    // ratio_select_a ratio, forced 1:1 when ratio_select_a disabled
    assign ratio_select_a_log2 = ctrl_reg.ratio_select_a_enable ? {1'b0, ctrl_reg.ratio_select_a} : 4'h0;

    cddc_pow2_div #(.MAXLOG(8)) u_ratio_select_a_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_en(rc_tick),
        .i_log2(ratio_select_a_log2),
        .o_tick(periph_tick)
    );

    assign o_ctrl = ctrl_reg;
    assign o_ticks = '{rc_tick: rc_tick, cpu_tick: rc_tick, periph_tick: periph_tick};

    // cpu ticks counted since the last periph tick, for checking the ratio
    logic [7:0] chk_cnt_reg;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            chk_cnt_reg <= 8'h00;
        end else if (rc_tick) begin
            chk_cnt_reg <= periph_tick ? 8'h00 : chk_cnt_reg + 8'h01;
        end
    end

    a_roi_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        i_irq_event && ctrl_reg.recover_on_interrupt && !wr_ctrl |=> !ctrl_reg.ratio_select_a_enable)
        else $error("ratio_select_a not cleared by interrupt");
    a_roi_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
        i_irq_event && !ctrl_reg.recover_on_interrupt && !wr_ctrl
        |=> $stable(ctrl_reg.ratio_select_a_enable))
        else $error("ratio_select_a changed with roi clear");
    a_ratio_period: assert property (@(posedge i_clk) disable iff (i_rst)
        rc_tick && ctrl_reg.ratio_select_a_enable && !periph_tick
        |-> chk_cnt_reg < ((8'h01 << ctrl_reg.ratio_select_a) - 8'h01))
        else $error("peripheral period exceeds ratio");
    a_ratio_select_a_applies: assert property (@(posedge i_clk) disable iff (i_rst)
        ctrl_reg.ratio_select_a_enable && ctrl_reg.ratio_select_a != 3'h0 && periph_tick
        ##1 ($stable(ctrl_reg) [*1]) |-> !periph_tick)
        else $error("ratio not applied");
    a_no_ratio_select_a_equal: assert property (@(posedge i_clk) disable iff (i_rst)
        !ctrl_reg.ratio_select_a_enable |-> periph_tick == rc_tick)
        else $error("rates differ without ratio_select_a");
    a_frc_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (current_osc_select_reg == CDDC_CURRENT_OSC_SELECT_FRC) && $stable(current_osc_select_reg) && $stable(ctrl_reg)
        |=> rc_hz_reg == (32'(CDDC_FRC_HZ) >> $past(rc_log2)))
        else $error("wrong frc rate");
    a_lprc_rate: assert property (@(posedge i_clk) disable iff (i_rst)
        (current_osc_select_reg == CDDC_CURRENT_OSC_SELECT_LPRC) && $stable(ctrl_reg)
        |=> rc_hz_reg == (32'(CDDC_LPRC_HZ) >> $past(rc_log2)))
        else $error("wrong lprc rate");
    a_low_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_en && i_paddr == CDDC_ADDR_CTRL |=> o_prdata[31:16] == 16'h0000 && o_prdata[7:0] == 8'h00)
        else $error("unimplemented bits nonzero");
    a_osc_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1 |=> current_osc_select_reg == $past(i_current_osc_select))
        else $error("osc code not followed");
    a_reset_div: assert property (@(posedge i_clk)
        $fell(i_rst) |-> ctrl_reg.rc_postscaler_select == 3'h1)
        else $error("postscaler reset value wrong");

    c_irq_recover: cover property (@(posedge i_clk) disable iff (i_rst)
        ctrl_reg.ratio_select_a_enable ##1 !ctrl_reg.ratio_select_a_enable && $past(i_irq_event));
    c_ratio_select_a_max: cover property (@(posedge i_clk) disable iff (i_rst)
        ctrl_reg.ratio_select_a_enable && ctrl_reg.ratio_select_a == 3'h7 && periph_tick);
    c_lprc: cover property (@(posedge i_clk) disable iff (i_rst)
        current_osc_select_reg == CDDC_CURRENT_OSC_SELECT_LPRC && rc_tick);
endmodule : cddc_top
